// ===== hw/rcl_map.svh
// constants for the reset configuration latch block: offsets, fields, resets
// assumes a 32-bit axi4-lite slave with one register per aligned word
`ifndef RCL_MAP_SVH
`define RCL_MAP_SVH
// register indices; byte address is four times the index
`define RCL_IDX_DRIVE_LO 4'h0
`define RCL_IDX_DRIVE_HI 4'h1
`define RCL_IDX_PIN_DBG 4'h2
`define RCL_IDX_PHS_ECC 4'h3
`define RCL_IDX_LIVE_BASE 4'h4
`define RCL_IDX_LIVE_TOP 4'h7
`define RCL_IDX_STATUS 4'h8
`define RCL_NUM_LATCH 4
// field positions
`define RCL_B2_EXT_BIT 7
`define RCL_B2_DBG_BIT 6
`define RCL_P15_LSB 0
`define RCL_B3_PHS_LSB 4
`define RCL_B3_ECC_BIT 3
`define RCL_B3_DPS_LSB 0
`define RCL_NUM_PORTS 9
`define RCL_PORT_PINS 8
`define RCL_NUM_PINS 72
`define RCL_EXT_PORT 1
`define RCL_EXT_BIT 2
`define RCL_EXT_PIN_IX 10
// synchroniser reset value: the shared reset pin idles high
`define RCL_SYNC_IDLE 72'h000000000000000400
// factory contents; ext reset bit is or-ed in from a strap parameter
`define RCL_FACT_B0 8'h00
`define RCL_FACT_B1 8'h00
`define RCL_FACT_B2 8'h40
`define RCL_FACT_B3 8'h08
// bus answers
`define RCL_RESP_OKAY 2'h0
`define RCL_RESP_SLVERR 2'h2
`endif

// ===== hw/rcl_pkg.sv
// types shared by the reset configuration latch block
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package rcl_pkg;
   typedef enum logic [1:0] {
      DRV_HIZ_ANALOG,
      DRV_HIZ_DIGITAL,
      DRV_PULL_UP,
      DRV_PULL_DOWN
   } rcl_drive_t;
   typedef struct packed {
      logic [7:0] out_drv_en;
      logic [7:0] in_buf_en;
      logic [7:0] pull_up;
      logic [7:0] pull_down;
   } rcl_port_ctl_t;
   typedef struct packed {
      logic ext_reset_sel;
      logic debug_en;
      logic ecc_en;
      logic ecc_bytes_free;
      logic [1:0] debug_port;
      logic [3:0] phase_delay;
   } rcl_sys_cfg_t;
   typedef enum logic {ST_LOAD, ST_RUN} rcl_state_t;
endpackage
`default_nettype wire

// ===== hw/rcl_port_decode.sv
// one port: turns a two-bit reset drive field into per-pin pad controls
// assumes the field only changes when the latches are reloaded
`default_nettype none
module rcl_port_decode (
   input wire logic aclk,
   input wire logic aresetn,
   input wire rcl_pkg::rcl_drive_t drive,
   input wire logic [7:0] reset_pin_mask,
   output var rcl_pkg::rcl_port_ctl_t port_ctl
);
   rcl_pkg::rcl_port_ctl_t ctl_reg;
   rcl_pkg::rcl_port_ctl_t ctl_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      ctl_next = '0;
      unique case (drive)
         rcl_pkg::DRV_HIZ_ANALOG: begin
            ctl_next = '0;
         end
         rcl_pkg::DRV_HIZ_DIGITAL: begin
            ctl_next.in_buf_en = 8'hff;
         end
         rcl_pkg::DRV_PULL_UP: begin
            ctl_next.in_buf_en = 8'hff;
            ctl_next.out_drv_en = 8'hff;
            ctl_next.pull_up = 8'hff;
         end
         rcl_pkg::DRV_PULL_DOWN: begin
            ctl_next.in_buf_en = 8'hff;
            ctl_next.out_drv_en = 8'hff;
            ctl_next.pull_down = 8'hff;
         end
      endcase
      // a pin lent to the reset function is a plain input, never driven
      ctl_next.out_drv_en = ctl_next.out_drv_en & ~reset_pin_mask;
      ctl_next.pull_up = ctl_next.pull_up & ~reset_pin_mask;
      ctl_next.pull_down = ctl_next.pull_down & ~reset_pin_mask;
      ctl_next.in_buf_en = ctl_next.in_buf_en | reset_pin_mask;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_reg <= '0;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign port_ctl = ctl_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_analog_all_off: assert property (
      (drive == rcl_pkg::DRV_HIZ_ANALOG && reset_pin_mask == 8'h00)
      |=> (ctl_reg.out_drv_en == 8'h00 && ctl_reg.in_buf_en == 8'h00))
      else $error("analog mode left a driver or input buffer on");
   a_pull_up_mode: assert property (
      (drive == rcl_pkg::DRV_PULL_UP && reset_pin_mask == 8'h00)
      |=> (ctl_reg.pull_up == 8'hff && ctl_reg.pull_down == 8'h00))
      else $error("pull up mode decoded wrongly");
   a_port_uniform: assert property (
      (reset_pin_mask == 8'h00) |=> ((ctl_reg.in_buf_en == 8'h00
      || ctl_reg.in_buf_en == 8'hff) && (ctl_reg.pull_down == 8'h00
      || ctl_reg.pull_down == 8'hff)))
      else $error("pins of one port differ in reset mode");
endmodule // rcl_port_decode
`default_nettype wire

// ===== hw/rcl_config_latches.sv
// reset configuration latches: four software-written bytes applied at reset
// assumes an axi4-lite master on aclk and pad inputs from outside the domain
//
// Chosen here: register access over AXI4-Lite.
`default_nettype none
`include "rcl_map.svh"
module rcl_config_latches #(
   parameter logic EXT_RESET_FACTORY = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cold_start_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [`RCL_NUM_PINS-1:0] pin_in,
   output logic [`RCL_NUM_PINS-1:0] pin_in_data,
   output logic ext_reset_req,
   output var rcl_pkg::rcl_port_ctl_t [`RCL_NUM_PORTS-1:0] port_ctl,
   output var rcl_pkg::rcl_sys_cfg_t sys_cfg,
   output logic config_loading
);
   logic [3:0][7:0] nv_reg;
   logic [3:0][7:0] nv_next;
   logic [3:0][7:0] live_reg;
   logic [3:0][7:0] live_next;
   rcl_pkg::rcl_state_t state_reg;
   rcl_pkg::rcl_state_t state_next;
   logic aw_held_reg, aw_held_next;
   logic w_held_reg, w_held_next;
   logic [3:0] widx_reg, widx_next;
   logic widx_ok_reg, widx_ok_next;
   logic [7:0] wbyte_reg, wbyte_next;
   logic wlane_reg, wlane_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [`RCL_NUM_PINS-1:0] sync1_reg, sync2_reg, pin_data_reg, pin_data_next;
   logic ext_req_reg, ext_req_next;
   logic [`RCL_NUM_PINS-1:0] in_buf_flat;
   logic [7:0] ext_pin_mask;
   logic wr_fire;
   logic [3:0] ridx;
   logic ridx_ok;

   ////////////////////////////////////////////////////////////////////////////
   // latch array: survives the warm reset, only cold start restores factory
   always_comb begin
      nv_next = nv_reg;
      if (wr_fire && widx_ok_reg && widx_reg < `RCL_NUM_LATCH && wlane_reg) begin
         nv_next[widx_reg[1:0]] = wbyte_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!cold_start_n) begin
         nv_reg[0] <= `RCL_FACT_B0;
         nv_reg[1] <= `RCL_FACT_B1;
         nv_reg[2] <= `RCL_FACT_B2 | {EXT_RESET_FACTORY, 7'h00};
         nv_reg[3] <= `RCL_FACT_B3;
      end else begin
         nv_reg <= nv_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // live copy: taken from the latches only in the load cycle after reset
   always_comb begin
      live_next = live_reg;
      state_next = state_reg;
      unique case (state_reg)
         rcl_pkg::ST_LOAD: begin
            live_next = nv_reg;
            state_next = rcl_pkg::ST_RUN;
         end
         rcl_pkg::ST_RUN: begin
            live_next = live_reg;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= rcl_pkg::ST_LOAD;
         live_reg <= '0;
      end else begin
         state_reg <= state_next;
         live_reg <= live_next;
      end
   end

   assign config_loading = (state_reg == rcl_pkg::ST_LOAD);
   assign sys_cfg.ext_reset_sel = live_reg[2][`RCL_B2_EXT_BIT];
   assign sys_cfg.debug_en = live_reg[2][`RCL_B2_DBG_BIT];
   assign sys_cfg.ecc_en = live_reg[3][`RCL_B3_ECC_BIT];
   assign sys_cfg.ecc_bytes_free = ~live_reg[3][`RCL_B3_ECC_BIT];
   assign sys_cfg.debug_port = live_reg[3][`RCL_B3_DPS_LSB +: 2];
   assign sys_cfg.phase_delay = live_reg[3][`RCL_B3_PHS_LSB +: 4];

   ////////////////////////////////////////////////////////////////////////////
   // per-port pad control
   assign ext_pin_mask = {5'h00, sys_cfg.ext_reset_sel, 2'h0};

   for (genvar p = 0; p < `RCL_NUM_PORTS; p++) begin : g_port
      localparam int BYTE_IX = (p < 8) ? p / 4 : 2;
      localparam int FLD_LSB = (p < 8) ? (p % 4) * 2 : `RCL_P15_LSB;
      rcl_port_decode u_dec (
         .aclk(aclk),
         .aresetn(aresetn),
         .drive(rcl_pkg::rcl_drive_t'(live_reg[BYTE_IX][FLD_LSB +: 2])),
         .reset_pin_mask((p == `RCL_EXT_PORT) ? ext_pin_mask : 8'h00),
         .port_ctl(port_ctl[p])
      );
      assign in_buf_flat[p*`RCL_PORT_PINS +: `RCL_PORT_PINS] = port_ctl[p].in_buf_en;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pad inputs: two-stage sync, then gated by the input buffer enables
   always_comb begin
      pin_data_next = sync2_reg & in_buf_flat;
      ext_req_next = sys_cfg.ext_reset_sel & ~sync2_reg[`RCL_EXT_PIN_IX];
      if (sys_cfg.ext_reset_sel) begin
         pin_data_next[`RCL_EXT_PIN_IX] = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // reset pin idles high; a low reset value would fake a request
         sync1_reg <= `RCL_SYNC_IDLE;
         sync2_reg <= `RCL_SYNC_IDLE;
         pin_data_reg <= '0;
         ext_req_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         pin_data_reg <= pin_data_next;
         ext_req_reg <= ext_req_next;
      end
   end

   assign pin_in_data = pin_data_reg;
   assign ext_reset_req = ext_req_reg;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write: address and data taken in either order, then answered
   assign awready = (state_reg == rcl_pkg::ST_RUN) && !aw_held_reg;
   assign wready = (state_reg == rcl_pkg::ST_RUN) && !w_held_reg;
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      widx_next = widx_reg;
      widx_ok_next = widx_ok_reg;
      wbyte_next = wbyte_reg;
      wlane_next = wlane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (awvalid && awready) begin
         aw_held_next = 1'b1;
         widx_next = awaddr[5:2];
         widx_ok_next = (awaddr[31:6] == 26'h0) && (awaddr[1:0] == 2'h0);
      end
      if (wvalid && wready) begin
         w_held_next = 1'b1;
         wbyte_next = wdata[7:0];
         wlane_next = wstrb[0];
      end
      if (wr_fire) begin
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         // only the latch bytes are writable; the live copy is read only
         bresp_next = (widx_ok_reg && widx_reg < `RCL_NUM_LATCH) ?
            `RCL_RESP_OKAY : `RCL_RESP_SLVERR;
      end
      if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         widx_reg <= 4'h0;
         widx_ok_reg <= 1'b0;
         wbyte_reg <= 8'h00;
         wlane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `RCL_RESP_OKAY;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         widx_reg <= widx_next;
         widx_ok_reg <= widx_ok_next;
         wbyte_reg <= wbyte_next;
         wlane_reg <= wlane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
      end
   end

   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read: latches, live copy, and a reload-pending status bit
   assign arready = (state_reg == rcl_pkg::ST_RUN) && !rvalid_reg;
   assign ridx = araddr[5:2];
   assign ridx_ok = (araddr[31:6] == 26'h0) && (araddr[1:0] == 2'h0);

   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (arvalid && arready) begin
         rvalid_next = 1'b1;
         rdata_next = 32'h0;
         rresp_next = `RCL_RESP_OKAY;
         if (!ridx_ok || ridx > `RCL_IDX_STATUS) begin
            rresp_next = `RCL_RESP_SLVERR;
         end else if (ridx < `RCL_NUM_LATCH) begin
            rdata_next = {24'h0, nv_reg[ridx[1:0]]};
         end else if (ridx <= `RCL_IDX_LIVE_TOP) begin
            rdata_next = {24'h0, live_reg[ridx[1:0]]};
         end else begin
            rdata_next = {31'h0, (nv_reg != live_reg)};
         end
      end else if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= `RCL_RESP_OKAY;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [3:0][7:0] chk_nv_d_reg;
   logic [1:0] chk_ridx_reg;
   always_ff @(posedge aclk) begin
      chk_nv_d_reg <= nv_reg;
      chk_ridx_reg <= ridx[1:0];
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_latch_write;
      wr_fire && widx_ok_reg && widx_reg < `RCL_NUM_LATCH && wlane_reg;
   endsequence
   sequence s_write_ok;
      bvalid_reg && bresp_reg == `RCL_RESP_OKAY;
   endsequence

   a_load_copies_latch: assert property (
      (state_reg == rcl_pkg::ST_LOAD) |=> (live_reg == chk_nv_d_reg
      && state_reg == rcl_pkg::ST_RUN))
      else $error("live copy not loaded from latches after reset");
   a_live_held_run: assert property (
      (state_reg == rcl_pkg::ST_RUN) |=> $stable(live_reg))
      else $error("live configuration changed outside reset");
   a_write_lands_latch: assert property (
      s_latch_write |=> s_write_ok ##0 (nv_reg[$past(widx_reg[1:0])] == $past(wbyte_reg)))
      else $error("latch write not stored or not answered okay");
   a_read_latch_byte: assert property (
      (arvalid && arready && ridx_ok && ridx < `RCL_NUM_LATCH)
      |=> (rvalid_reg && rdata_reg == {24'h0, chk_nv_d_reg[chk_ridx_reg]}))
      else $error("latch read returned wrong byte");
   a_ext_reset_follow: assert property (
      (!sys_cfg.ext_reset_sel) |=> !ext_req_reg)
      else $error("reset request raised while pin is gpio");
   a_no_false_request: assert property (
      (state_reg == rcl_pkg::ST_LOAD) |=> !ext_req_reg ##1 !ext_req_reg)
      else $error("reset request raised before the pin was sampled");
   a_debug_enable_load: assert property (
      (state_reg == rcl_pkg::ST_LOAD)
      |=> (sys_cfg.debug_en == chk_nv_d_reg[2][`RCL_B2_DBG_BIT]))
      else $error("debug enable not taken from latch");
   a_ecc_bytes_load: assert property (
      (state_reg == rcl_pkg::ST_LOAD) |=> (sys_cfg.ecc_en
      == chk_nv_d_reg[3][`RCL_B3_ECC_BIT] && sys_cfg.ecc_bytes_free != sys_cfg.ecc_en))
      else $error("ecc enable or byte release wrong");
   a_debug_port_load: assert property (
      (state_reg == rcl_pkg::ST_LOAD)
      |=> (sys_cfg.debug_port == chk_nv_d_reg[3][`RCL_B3_DPS_LSB +: 2]))
      else $error("debug port select not taken from latch");
   a_phase_delay_load: assert property (
      (state_reg == rcl_pkg::ST_LOAD)
      |=> (sys_cfg.phase_delay == chk_nv_d_reg[3][`RCL_B3_PHS_LSB +: 4]))
      else $error("phase delay not taken from latch");
endmodule // rcl_config_latches
`default_nettype wire

// ===== test/test_reset_config_latches.sv
// bench for the reset configuration latch block: reference model, bus tasks, checks
// assumes the design files and rcl_map.svh on the include path, one 50 MHz clock
`default_nettype none
`include "rcl_map.svh"
module test_reset_config_latches;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic EXT_F = 1'b0;
   logic aclk, aresetn, cold_start_n;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [71:0] pin_in, pin_in_data, p;
   logic ext_reset_req, config_loading;
   rcl_pkg::rcl_port_ctl_t [`RCL_NUM_PORTS-1:0] port_ctl;
   rcl_pkg::rcl_sys_cfg_t sys_cfg;
   int n_fail, checks, v;
   int m_lat[4], m_live[4];

   rcl_config_latches #(.EXT_RESET_FACTORY(EXT_F)) uut (
      .aclk(aclk), .aresetn(aresetn), .cold_start_n(cold_start_n),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .pin_in(pin_in), .pin_in_data(pin_in_data), .ext_reset_req(ext_reset_req),
      .port_ctl(port_ctl), .sys_cfg(sys_cfg), .config_loading(config_loading)
   );

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // address and data offered together, each dropped once taken
   task automatic axi_wr(input int a, input int d, input logic [3:0] s);
      bit ad, wd;
      ad = 0;
      wd = 0;
      awaddr <= 32'(a);
      wdata <= 32'(d);
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic wr(input int a, input int d, input logic [3:0] s);
      bit ok;
      ok = (a % 4 == 0) && (a < 16);
      axi_wr(a, d, s);
      chk({30'h0, r}, {30'h0, ok ? `RCL_RESP_OKAY : `RCL_RESP_SLVERR}, "bresp");
      if (ok && s[0])
         m_lat[a/4] = d & 255;
   endtask

   task automatic rd(input int a);
      int e;
      logic [1:0] er;
      er = `RCL_RESP_OKAY;
      if (a % 4 != 0 || a > 32) begin
         e = 0;
         er = `RCL_RESP_SLVERR;
      end
      else if (a < 16)
         e = m_lat[a/4];
      else if (a < 32)
         e = m_live[a/4-4];
      else
         e = (m_lat != m_live) ? 1 : 0;
      araddr <= 32'(a);
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      chk(rdata, 32'(e), "rdata");
      chk({30'h0, rresp}, {30'h0, er}, "rresp");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   function automatic int code_of(int k);
      if (k < 4)
         return (m_live[0] >> (2*k)) & 3;
      if (k < 8)
         return (m_live[1] >> (2*(k-4))) & 3;
      return m_live[2] & 3;
   endfunction

   function automatic logic [31:0] exp_port(int k);
      logic [31:0] e;
      case (code_of(k))
         1: e = 32'h00ff0000;
         2: e = 32'hffffff00;
         3: e = 32'hffff00ff;
         default: e = 32'h00000000;
      endcase
      // shared reset pin keeps only its input buffer
      if (k == `RCL_EXT_PORT && m_live[2][`RCL_B2_EXT_BIT])
         e = (e & ~(32'h01010101 << `RCL_EXT_BIT)) | (32'h00010000 << `RCL_EXT_BIT);
      return e;
   endfunction

   function automatic logic [9:0] exp_sys();
      logic [7:0] b2, b3;
      b2 = 8'(m_live[2]);
      b3 = 8'(m_live[3]);
      return {b2[7], b2[6], b3[3], !b3[3], b3[1:0], b3[7:4]};
   endfunction

   task automatic check_outs();
      for (int k = 0; k < `RCL_NUM_PORTS; k++)
         chk(port_ctl[k], exp_port(k), "port ctl");
      chk({22'h0, sys_cfg}, {22'h0, exp_sys()}, "sys cfg");
   endtask

   task automatic pins(input logic [71:0] pv);
      logic [71:0] e;
      logic [31:0] pc;
      pin_in <= pv;
      repeat (5) @(posedge aclk);
      for (int i = 0; i < 72; i++) begin
         pc = exp_port(i / 8);
         e[i] = pv[i] & pc[16 + i % 8];
      end
      if (m_live[2][`RCL_B2_EXT_BIT])
         e[`RCL_EXT_PIN_IX] = 1'b0;
      for (int i = 0; i < 3; i++)
         chk(32'(pin_in_data >> (32*i)), 32'(e >> (32*i)), "pin data");
      chk({31'h0, ext_reset_req}, {31'h0, m_live[2][7] & !pv[10]}, "ext req");
   endtask

   // latches survive a warm reset; a cold one restores factory bytes
   task automatic do_reset(input bit cold);
      aresetn <= 1'b0;
      cold_start_n <= !cold;
      repeat (4) @(posedge aclk);
      chk({31'h0, config_loading}, 32'h1, "loading");
      chk(port_ctl[0], 32'h0, "reset ctl");
      aresetn <= 1'b1;
      cold_start_n <= 1'b1;
      if (cold)
         m_lat = '{0, 0, EXT_F ? 'hc0 : 'h40, 8};
      m_live = m_lat;
      repeat (3) begin
         @(posedge aclk);
         if (pin_in[`RCL_EXT_PIN_IX])
            chk({31'h0, ext_reset_req}, 32'h0, "false reset req");
      end
      check_outs();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0;
      cold_start_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 32'h0;
      wdata = 32'h0;
      araddr = 32'h0;
      wstrb = 4'h0;
      pin_in = '0;
      n_fail = 0;
      checks = 0;
      void'($urandom(80940));
      @(posedge aclk);
      do_reset(1'b1);
      for (int a = 0; a <= 36; a += 4)
         rd(a);
      wr(64, 8'h5a, 4'h1);
      rd(64);
      wr(2, 8'h11, 4'h1);
      wr(16, 8'hff, 4'h1);
      wr(0, 8'hff, 4'h0);
      rd(0);
      for (int it = 0; it < 8; it++) begin
         v = (it < 4) ? it * 'h55 : $urandom;
         wr(0, v, 4'h1);
         wr(4, (it < 4) ? v : $urandom, 4'h1);
         wr(8, ($urandom & 'h7c) | (it[0] << 7) | (it & 3), 4'h1);
         wr(12, $urandom, 4'h1);
         for (int a = 0; a <= 32; a += 4)
            rd(a);
         check_outs();
         do_reset(1'b0);
         rd(32);
         p = 72'({$urandom, $urandom, $urandom});
         p[10] = 1'b0;
         pins(p);
         p[10] = 1'b1;
         pins(p);
      end
      do_reset(1'b1);
      for (int a = 0; a <= 12; a += 4)
         rd(a);
      end_sim();
   end

   // normal run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      n_fail++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      end_sim();
   end
endmodule // test_reset_config_latches
`default_nettype wire
